// *** rtl/stsd_pkg.sv ***
`default_nettype none
package stsd_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 24;
    localparam int unsigned CLK_CODE_W = 3;
    localparam int unsigned SRC_CODE_W = 5;

    // Register indices on the plain register port.
    localparam logic [ADDR_W-1:0] OFS_CLK_SEL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_WIN_SEL   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_SIG_SEL   = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CNT_LOW   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CNT_HIGH  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CNT_UPPER = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CPR_LOW   = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_CPR_HIGH  = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_CPR_UPPER = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CPW_LOW   = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_CPW_HIGH  = 4'ha;
    localparam logic [ADDR_W-1:0] OFS_CPW_UPPER = 4'hb;

    // Field positions: codes sit at bit 0 of their register; counter bytes start at bits 0, 8 and 16 of the counter.
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned LOW_LSB  = 0;
    localparam int unsigned HIGH_LSB = 8;
    localparam int unsigned UPPER_LSB = 16;

    // Reset values.
    localparam logic [CLK_CODE_W-1:0] RST_CLK_CODE = 3'h0;
    localparam logic [SRC_CODE_W-1:0] RST_SRC_CODE = 5'h00;
    localparam logic [CNT_W-1:0]      RST_COUNTER  = 24'h000000;
    localparam logic [DATA_W-1:0]     RST_RDATA    = 8'h00;

    // Selected codes used by the built-in checks.
    localparam logic [CLK_CODE_W-1:0] CLK_INSTR    = 3'h0;
    localparam logic [CLK_CODE_W-1:0] CLK_MED_OSC  = 3'h4;
    localparam logic [CLK_CODE_W-1:0] CLK_REF_OUT  = 3'h7;
    localparam logic [SRC_CODE_W-1:0] WIN_PIN      = 5'h00;
    localparam logic [SRC_CODE_W-1:0] WIN_CCP_ONE  = 5'h09;
    localparam logic [SRC_CODE_W-1:0] WIN_RSVD     = 5'h11;
    localparam logic [SRC_CODE_W-1:0] SIG_T0_ROLL  = 5'h01;
    localparam logic [SRC_CODE_W-1:0] SIG_CLC_ONE  = 5'h16;

    typedef struct packed {
        logic reference_clock_out;
        logic secondary_crystal_osc;
        logic medium_freq_div16;
        logic medium_freq_internal_osc;
        logic low_freq_internal_osc;
        logic high_freq_internal_osc;
        logic sys_clk;
        logic instr_clk;
    } stsd_osc_t;

    typedef struct packed {
        logic       timer_zero_rollover;
        logic [5:0] timer_postscaled;
        logic [3:0] capture_compare_output;
        logic [3:0] pwm_output;
        logic       osc_controller_output;
        logic [1:0] comparator_output;
        logic       zero_cross_output;
        logic [3:0] logic_cell_output;
    } stsd_periph_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } stsd_bus_t;

endpackage
`default_nettype wire

// *** rtl/stsd_select.sv ***
`timescale 1ns/10ps
`default_nettype none
module stsd_select #(
    parameter int unsigned CODE_W = 5
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 clk_en_i,
    input  wire logic [CODE_W-1:0]    code_i,
    input  wire logic [2**CODE_W-1:0] sources_i,
    input  wire logic                 invert_i,
    output var  logic                 selected_o
);

    logic picked;

    assign picked = sources_i[code_i] ^ invert_i;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            selected_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            selected_o <= picked;
        end
    end

endmodule
`default_nettype wire

// *** rtl/stsd_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
module stsd_latch #(
    parameter int unsigned W = 24
) (
    input  wire logic         clk_i,
    input  wire logic         clk_en_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output var  logic [W-1:0] held_o
);

    // No reset: the held value stays unknown until the first capture.
    always_ff @(posedge clk_i)
    begin
        if (clk_en_i && load_i)
        begin
            held_o <= value_i;
        end
    end

endmodule
`default_nettype wire

// *** rtl/stsd_regs.sv ***
// Behaviour
// - Clock code 000 instruction clock, 001 system clock.
// - Clock code 010 fast oscillator, 011 slow oscillator.
// - Clock code 100 medium oscillator, 101 divided.
// - Clock code 110 crystal, 111 reference clock.
// - Window codes 0 to 4: pin and oscillators.
// - Window codes: timers, capture outputs, pwm outputs.
// - Window codes: controller, comparators, zero-cross, cells.
// - Signal codes: pin, rollover, timers one to six.
// - Signal codes: capture, pwm, comparators, cells.
// - Counter bytes readable, writable, cleared at reset.
// - Captured period: three read-only bytes, undefined.
// - Captured width low and high bytes read-only.
// - Captured width upper byte read-only, undefined.
// - Polarity one inverts window and signal inputs.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module stsd_regs (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      clk_en_i,
    input  wire stsd_pkg::stsd_bus_t       reg_bus_i,
    output var  logic [7:0]                reg_rdata_o,
    input  wire stsd_pkg::stsd_osc_t       osc_i,
    input  wire stsd_pkg::stsd_periph_t    periph_i,
    input  wire logic                      window_pin_input_i,
    input  wire logic                      signal_pin_input_i,
    input  wire logic                      window_polarity_i,
    input  wire logic                      signal_polarity_i,
    input  wire logic                      counter_inc_i,
    input  wire logic                      counter_clear_i,
    input  wire logic                      capture_period_i,
    input  wire logic                      capture_width_i,
    output var  logic                      timer_clock_o,
    output var  logic                      window_input_o,
    output var  logic                      measured_signal_input_o,
    output var  logic [23:0]               measurement_counter_o,
    output var  logic [23:0]               captured_period_o,
    output var  logic [23:0]               captured_pulse_width_o
);

    logic [stsd_pkg::CLK_CODE_W-1:0] clock_code_q;
    logic [stsd_pkg::SRC_CODE_W-1:0] window_code_q;
    logic [stsd_pkg::SRC_CODE_W-1:0] signal_code_q;
    logic [stsd_pkg::CNT_W-1:0]      counter_q;
    logic [stsd_pkg::CNT_W-1:0]      counter_d;
    logic [stsd_pkg::DATA_W-1:0]     rdata_d;
    logic [7:0]                      clock_sources;
    logic [31:0]                     window_sources;
    logic [31:0]                     signal_sources;
    logic                            wr_clk;
    logic                            wr_win;
    logic                            wr_sig;
    logic                            wr_low;
    logic                            wr_high;
    logic                            wr_upper;
    logic                            wr_any_byte;
    logic [7:0]                      next_low;
    logic [7:0]                      next_high;
    logic [7:0]                      next_upper;

    // Register write decode.
    assign wr_clk   = reg_bus_i.wr && reg_bus_i.addr == stsd_pkg::OFS_CLK_SEL;
    assign wr_win   = reg_bus_i.wr && reg_bus_i.addr == stsd_pkg::OFS_WIN_SEL;
    assign wr_sig   = reg_bus_i.wr && reg_bus_i.addr == stsd_pkg::OFS_SIG_SEL;
    assign wr_low   = reg_bus_i.wr && reg_bus_i.addr == stsd_pkg::OFS_CNT_LOW;
    assign wr_high  = reg_bus_i.wr && reg_bus_i.addr == stsd_pkg::OFS_CNT_HIGH;
    assign wr_upper = reg_bus_i.wr
                      && reg_bus_i.addr == stsd_pkg::OFS_CNT_UPPER;
    assign wr_any_byte = wr_low || wr_high || wr_upper;

    // Source vectors are indexed directly by the selection code.
    assign clock_sources = {
        osc_i.reference_clock_out,
        osc_i.secondary_crystal_osc,
        osc_i.medium_freq_div16,
        osc_i.medium_freq_internal_osc,
        osc_i.low_freq_internal_osc,
        osc_i.high_freq_internal_osc,
        osc_i.sys_clk,
        osc_i.instr_clk
    };

    // Reserved and unassigned codes select a constant low input.
    assign window_sources = {
        5'h00,
        periph_i.logic_cell_output,
        periph_i.zero_cross_output,
        periph_i.comparator_output,
        periph_i.osc_controller_output,
        2'h0,
        periph_i.pwm_output,
        periph_i.capture_compare_output,
        periph_i.timer_postscaled[5],
        periph_i.timer_postscaled[3],
        periph_i.timer_postscaled[1],
        1'b0,
        osc_i.reference_clock_out,
        osc_i.secondary_crystal_osc,
        osc_i.medium_freq_div16,
        osc_i.low_freq_internal_osc,
        window_pin_input_i
    };

    assign signal_sources = {
        6'h00,
        periph_i.logic_cell_output,
        periph_i.zero_cross_output,
        periph_i.comparator_output,
        periph_i.osc_controller_output,
        2'h0,
        periph_i.pwm_output,
        periph_i.capture_compare_output,
        periph_i.timer_postscaled,
        periph_i.timer_zero_rollover,
        signal_pin_input_i
    };

    // A byte write replaces only its own byte and wins over counting,
    // so software never sees a half-incremented value it just wrote.
    assign next_low   = wr_low ? reg_bus_i.wdata
                               : counter_q[stsd_pkg::LOW_LSB +: 8];
    assign next_high  = wr_high ? reg_bus_i.wdata
                                : counter_q[stsd_pkg::HIGH_LSB +: 8];
    assign next_upper = wr_upper ? reg_bus_i.wdata
                                 : counter_q[stsd_pkg::UPPER_LSB +: 8];

    assign counter_d = wr_any_byte ? {next_upper, next_high, next_low}
                     : counter_clear_i ? stsd_pkg::RST_COUNTER
                     : counter_inc_i ? counter_q + 24'h000001
                     : counter_q;

    // Read multiplexer; unmapped indices read as zero.
    always_comb
    begin
        rdata_d = stsd_pkg::RST_RDATA;
        unique case (reg_bus_i.addr)
            stsd_pkg::OFS_CLK_SEL:
                rdata_d = {5'h00, clock_code_q};
            stsd_pkg::OFS_WIN_SEL:
                rdata_d = {3'h0, window_code_q};
            stsd_pkg::OFS_SIG_SEL:
                rdata_d = {3'h0, signal_code_q};
            stsd_pkg::OFS_CNT_LOW:
                rdata_d = counter_q[stsd_pkg::LOW_LSB +: 8];
            stsd_pkg::OFS_CNT_HIGH:
                rdata_d = counter_q[stsd_pkg::HIGH_LSB +: 8];
            stsd_pkg::OFS_CNT_UPPER:
                rdata_d = counter_q[stsd_pkg::UPPER_LSB +: 8];
            stsd_pkg::OFS_CPR_LOW:
                rdata_d = captured_period_o[stsd_pkg::LOW_LSB +: 8];
            stsd_pkg::OFS_CPR_HIGH:
                rdata_d = captured_period_o[stsd_pkg::HIGH_LSB +: 8];
            stsd_pkg::OFS_CPR_UPPER:
                rdata_d = captured_period_o[stsd_pkg::UPPER_LSB +: 8];
            stsd_pkg::OFS_CPW_LOW:
                rdata_d = captured_pulse_width_o[stsd_pkg::LOW_LSB +: 8];
            stsd_pkg::OFS_CPW_HIGH:
                rdata_d = captured_pulse_width_o[stsd_pkg::HIGH_LSB +: 8];
            stsd_pkg::OFS_CPW_UPPER:
                rdata_d = captured_pulse_width_o[stsd_pkg::UPPER_LSB +: 8];
            default:
                rdata_d = stsd_pkg::RST_RDATA;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            clock_code_q  <= stsd_pkg::RST_CLK_CODE;
            window_code_q <= stsd_pkg::RST_SRC_CODE;
            signal_code_q <= stsd_pkg::RST_SRC_CODE;
        end
        else if (clk_en_i)
        begin
            if (wr_clk)
            begin
                clock_code_q <= reg_bus_i.wdata[stsd_pkg::CODE_LSB +: 3];
            end
            if (wr_win)
            begin
                window_code_q <= reg_bus_i.wdata[stsd_pkg::CODE_LSB +: 5];
            end
            if (wr_sig)
            begin
                signal_code_q <= reg_bus_i.wdata[stsd_pkg::CODE_LSB +: 5];
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            counter_q <= stsd_pkg::RST_COUNTER;
        end
        else if (clk_en_i)
        begin
            counter_q <= counter_d;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            reg_rdata_o <= stsd_pkg::RST_RDATA;
        end
        else if (clk_en_i)
        begin
            reg_rdata_o <= reg_bus_i.rd ? rdata_d : stsd_pkg::RST_RDATA;
        end
    end

    assign measurement_counter_o = counter_q;

    // The timer clock is sampled, so sources faster than half of clk_i
    // alias; that is the price of keeping one clock domain.
    stsd_select #(
        .CODE_W     (stsd_pkg::CLK_CODE_W)
    ) u_clock_select (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .clk_en_i   (clk_en_i),
        .code_i     (clock_code_q),
        .sources_i  (clock_sources),
        .invert_i   (1'b0),
        .selected_o (timer_clock_o)
    );

    stsd_select #(
        .CODE_W     (stsd_pkg::SRC_CODE_W)
    ) u_window_select (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .clk_en_i   (clk_en_i),
        .code_i     (window_code_q),
        .sources_i  (window_sources),
        .invert_i   (window_polarity_i),
        .selected_o (window_input_o)
    );

    stsd_select #(
        .CODE_W     (stsd_pkg::SRC_CODE_W)
    ) u_signal_select (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .clk_en_i   (clk_en_i),
        .code_i     (signal_code_q),
        .sources_i  (signal_sources),
        .invert_i   (signal_polarity_i),
        .selected_o (measured_signal_input_o)
    );

    stsd_latch #(
        .W          (stsd_pkg::CNT_W)
    ) u_period_latch (
        .clk_i      (clk_i),
        .clk_en_i   (clk_en_i),
        .load_i     (capture_period_i),
        .value_i    (counter_q),
        .held_o     (captured_period_o)
    );

    stsd_latch #(
        .W          (stsd_pkg::CNT_W)
    ) u_width_latch (
        .clk_i      (clk_i),
        .clk_en_i   (clk_en_i),
        .load_i     (capture_width_i),
        .value_i    (counter_q),
        .held_o     (captured_pulse_width_o)
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    chk_clk_instr: assert property (
        clk_en_i && !reset_i && clock_code_q == stsd_pkg::CLK_INSTR
        |=> timer_clock_o == $past(osc_i.instr_clk))
        else $error("Code 0 does not route the instruction clock.");

    chk_clk_medium: assert property (
        clk_en_i && clock_code_q == stsd_pkg::CLK_MED_OSC
        |=> timer_clock_o == $past(osc_i.medium_freq_internal_osc))
        else $error("Code 4 does not route the medium oscillator.");

    chk_clk_ref: assert property (
        clk_en_i && clock_code_q == stsd_pkg::CLK_REF_OUT
        |=> timer_clock_o == $past(osc_i.reference_clock_out))
        else $error("Code 7 does not route the reference clock.");

    chk_clk_write_read: assert property (
        clk_en_i && wr_clk ##1 clk_en_i && reg_bus_i.rd
        && reg_bus_i.addr == stsd_pkg::OFS_CLK_SEL
        |=> reg_rdata_o == {5'h00, $past(reg_bus_i.wdata[2:0], 2)})
        else $error("Clock selection does not read back.");

    chk_win_pin_pol: assert property (
        clk_en_i && !reset_i && window_code_q == stsd_pkg::WIN_PIN
        |=> window_input_o == ($past(window_pin_input_i)
                               ^ $past(window_polarity_i)))
        else $error("Window pin polarity is wrong.");

    chk_win_ccp: assert property (
        clk_en_i && window_code_q == stsd_pkg::WIN_CCP_ONE
        && !window_polarity_i
        |=> window_input_o == $past(periph_i.capture_compare_output[0]))
        else $error("Window code 9 does not route capture output one.");

    chk_win_reserved: assert property (
        clk_en_i && window_code_q == stsd_pkg::WIN_RSVD
        |=> window_input_o == $past(window_polarity_i))
        else $error("Reserved window code is not a constant input.");

    chk_sig_rollover: assert property (
        clk_en_i && signal_code_q == stsd_pkg::SIG_T0_ROLL
        |=> measured_signal_input_o == ($past(periph_i.timer_zero_rollover)
                                        ^ $past(signal_polarity_i)))
        else $error("Signal code 1 does not route the timer rollover.");

    chk_sig_cell: assert property (
        clk_en_i && signal_code_q == stsd_pkg::SIG_CLC_ONE
        |=> measured_signal_input_o == ($past(periph_i.logic_cell_output[0])
                                        ^ $past(signal_polarity_i)))
        else $error("Signal code 22 does not route logic cell one.");

    chk_cnt_byte_write: assert property (
        clk_en_i && wr_high
        |=> counter_q[15:8] == $past(reg_bus_i.wdata)
            && counter_q[7:0] == $past(counter_q[7:0])
            && counter_q[23:16] == $past(counter_q[23:16]))
        else $error("Counter byte write touched another byte.");

    chk_cnt_count: assert property (
        clk_en_i && counter_inc_i && !counter_clear_i && !wr_any_byte
        |=> counter_q == $past(counter_q) + 24'h000001)
        else $error("Counter did not advance by one.");

    chk_cnt_frozen: assert property (
        !clk_en_i |=> $stable(counter_q) && $stable(reg_rdata_o))
        else $error("State moved while the clock enable was low.");

    chk_cpr_capture: assert property (
        clk_en_i && capture_period_i ##1 clk_en_i && reg_bus_i.rd
        && reg_bus_i.addr == stsd_pkg::OFS_CPR_UPPER
        |=> reg_rdata_o == $past(counter_q[23:16], 2))
        else $error("Captured period upper byte is wrong.");

    chk_cpw_capture: assert property (
        clk_en_i && capture_width_i
        |=> captured_pulse_width_o == $past(counter_q))
        else $error("Captured width does not hold the counter.");

    chk_cpw_upper_read: assert property (
        clk_en_i && reg_bus_i.rd && reg_bus_i.addr == stsd_pkg::OFS_CPW_UPPER
        |=> reg_rdata_o == $past(captured_pulse_width_o[23:16]))
        else $error("Captured width upper byte read is wrong.");

    chk_rd_idle: assert property (
        clk_en_i && !reg_bus_i.rd |=> reg_rdata_o == 8'h00)
        else $error("Read data stand without a read strobe.");

endmodule
`default_nettype wire

// *** verification/stsd_src_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module stsd_src_model (
    input  wire logic                   clk_i,
    output var  stsd_pkg::stsd_osc_t    osc_o,
    output var  stsd_pkg::stsd_periph_t periph_o,
    output var  logic                   win_pin_o,
    output var  logic                   sig_pin_o
);
    // Every source is a level that changes often, so picking a neighbour
    // instead of the right source shows up within a few cycles.
    logic [33:0] pat_q = 34'h1a5c396e1;

    always_ff @(posedge clk_i)
    begin
        pat_q <= {pat_q[32:0], pat_q[33] ^ pat_q[26] ^ pat_q[1] ^ pat_q[0]};
    end

    assign {osc_o, periph_o, win_pin_o, sig_pin_o} = pat_q;
endmodule
`default_nettype wire

// *** verification/stsd_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module stsd_regs_tb;
    logic                   clk_i = 1'b0;
    logic                   reset_i = 1'b1;
    logic                   window_polarity = 1'b0;
    logic                   signal_polarity = 1'b0;
    logic                   inc = 1'b0;
    logic                   cap_p = 1'b0;
    logic                   cap_w = 1'b0;
    logic                   en = 1'b1;
    logic                   clr = 1'b0;
    stsd_pkg::stsd_bus_t    bus = '0;
    stsd_pkg::stsd_osc_t    osc, p_osc;
    stsd_pkg::stsd_periph_t per, p_per;
    logic                   wpin, spin, p_wp, p_sp, tclk, win, sig;
    logic [7:0]             rdata;
    logic [23:0]            cnt, cpr, cpw;
    logic [31:0]            wv, sv;
    int                     errors = 0;
    int                     tests_run = 0;
    int                     cycles = 0;

    always #10 clk_i = ~clk_i;

    stsd_src_model src_u (.clk_i(clk_i), .osc_o(osc), .periph_o(per),
        .win_pin_o(wpin), .sig_pin_o(spin));

    stsd_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(en),
        .reg_bus_i(bus), .reg_rdata_o(rdata), .osc_i(osc), .periph_i(per),
        .window_pin_input_i(wpin), .signal_pin_input_i(spin),
        .window_polarity_i(window_polarity), .signal_polarity_i(signal_polarity),
        .counter_inc_i(inc), .counter_clear_i(clr),
        .capture_period_i(cap_p), .capture_width_i(cap_w),
        .timer_clock_o(tclk), .window_input_o(win),
        .measured_signal_input_o(sig), .measurement_counter_o(cnt),
        .captured_period_o(cpr), .captured_pulse_width_o(cpw));

    // Sources as they stood before the latest edge, which is what the
    // registered selector outputs show until the next edge.
    always @(posedge clk_i)
    begin
        p_osc <= osc;
        p_per <= per;
        p_wp <= wpin;
        p_sp <= spin;
    end

    assign wv = {5'h00, p_per.logic_cell_output, p_per.zero_cross_output,
        p_per.comparator_output, p_per.osc_controller_output, 2'h0,
        p_per.pwm_output, p_per.capture_compare_output,
        p_per.timer_postscaled[5], p_per.timer_postscaled[3],
        p_per.timer_postscaled[1], 1'b0, p_osc.reference_clock_out,
        p_osc.secondary_crystal_osc, p_osc.medium_freq_div16,
        p_osc.low_freq_internal_osc, p_wp};
    assign sv = {6'h00, p_per.logic_cell_output, p_per.zero_cross_output,
        p_per.comparator_output, p_per.osc_controller_output, 2'h0,
        p_per.pwm_output, p_per.capture_compare_output,
        p_per.timer_postscaled, p_per.timer_zero_rollover, p_sp};

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {23'h0, e}, {23'h0, g});
    endtask

    // Write and read back with no idle cycle between the two strobes.
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d,
                         input logic [7:0] e);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1 chk("read_back", {16'h0000, e}, {16'h0000, rdata});
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1 chk("read_data", {16'h0000, e}, {16'h0000, rdata});
        @(posedge clk_i);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++)
            rd(i[3:0], 8'h00);
        rd(4'hc, 8'h00);
        $display("test reset_values done");
        for (int p = 0; p < 2; p++)
        begin
            window_polarity <= p[0];
            signal_polarity <= p[0];
            for (int c = 0; c < 32; c++)
            begin
                wr(stsd_pkg::OFS_WIN_SEL, {3'h7, c[4:0]});
                wr(stsd_pkg::OFS_SIG_SEL, {3'h7, c[4:0]});
                wr_rd(stsd_pkg::OFS_CLK_SEL, {3'h7, c[4:0]},
                      {5'h00, c[2:0]});
                rd(stsd_pkg::OFS_WIN_SEL, {3'h0, c[4:0]});
                rd(stsd_pkg::OFS_SIG_SEL, {3'h0, c[4:0]});
                repeat (4)
                begin
                    @(negedge clk_i);
                    chk1("timer_clock", p_osc[c[2:0]], tclk);
                    chk1("window", wv[c] ^ p[0], win);
                    chk1("signal", sv[c] ^ p[0], sig);
                end
                @(posedge clk_i);
            end
        end
        $display("test source_select done");
        wr(stsd_pkg::OFS_CNT_LOW, 8'h5a);
        wr(stsd_pkg::OFS_CNT_HIGH, 8'ha5);
        wr(stsd_pkg::OFS_CNT_UPPER, 8'h3c);
        chk("counter", 24'h3ca55a, cnt);
        wr(stsd_pkg::OFS_CNT_HIGH, 8'h11);
        chk("counter", 24'h3c115a, cnt);
        rd(stsd_pkg::OFS_CNT_HIGH, 8'h11);
        inc <= 1'b1;
        repeat (3) @(posedge clk_i);
        inc <= 1'b0;
        @(posedge clk_i);
        chk("counter", 24'h3c115d, cnt);
        cap_p <= 1'b1;
        @(posedge clk_i);
        cap_p <= 1'b0;
        rd(stsd_pkg::OFS_CPR_UPPER, 8'h3c);
        chk("period", 24'h3c115d, cpr);
        wr(stsd_pkg::OFS_CPR_LOW, 8'h00);
        rd(stsd_pkg::OFS_CPR_LOW, 8'h5d);
        rd(stsd_pkg::OFS_CPR_HIGH, 8'h11);
        rd(stsd_pkg::OFS_CPR_UPPER, 8'h3c);
        wr(stsd_pkg::OFS_CNT_UPPER, 8'hff);
        cap_w <= 1'b1;
        @(posedge clk_i);
        cap_w <= 1'b0;
        @(posedge clk_i);
        chk("width", 24'hff115d, cpw);
        wr(stsd_pkg::OFS_CPW_UPPER, 8'h00);
        rd(stsd_pkg::OFS_CPW_LOW, 8'h5d);
        rd(stsd_pkg::OFS_CPW_HIGH, 8'h11);
        rd(stsd_pkg::OFS_CPW_UPPER, 8'hff);
        $display("test counter_capture done");
        en <= 1'b0;
        inc <= 1'b1;
        repeat (3) @(posedge clk_i);
        en <= 1'b1;
        inc <= 1'b0;
        @(posedge clk_i);
        chk("counter", 24'hff115d, cnt);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        chk("counter", 24'h000000, cnt);
        rd(stsd_pkg::OFS_CLK_SEL, 8'h00);
        wr(stsd_pkg::OFS_CNT_LOW, 8'h42);
        chk("counter", 24'h000042, cnt);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        @(posedge clk_i);
        chk("counter", 24'h000000, cnt);
        $display("test enable_reset_clear done");
        stop_test();
    end
endmodule
`default_nettype wire
